// *** hdl/crac_core.sv ***
// Core reset combining and architectural register file with APB access
`timescale 1ns/100ps
module crac_core #(
  parameter int FILTER_CYC = crac_pkg::PIN_FILTER_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  regulator_pct,
  input  wire logic        supply_monitor,
  input  wire logic        ext_reset_pin_n_in,
  output logic             ext_reset_pin_n_out,
  output logic             ext_reset_pin_n_oe,
  input  wire logic        watchdog_counter_expired,
  input  wire logic        stop_mode,
  input  wire logic        sleep_mode,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire logic [7:0]  stack_push_data,
  input  wire logic [7:0]  movx_ri_low,
  output logic             sys_reset_n,
  output logic             internal_osc_en,
  output logic             internal_osc_sel,
  output logic             watchdog_counter_en,
  output logic      [7:0]  watchdog_counter_timeout,
  output logic      [19:0] boot_pc,
  output logic      [15:0] stack_addr,
  output logic      [7:0]  stack_pop_data,
  output logic      [15:0] movx_addr,
  output logic             wide_mode,
  output logic             compact_mode,
  output logic      [3:0]  fetch_wait_cycles_m1,
  output logic      [7:0]  port_two_latch
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset combining

  logic [15:0] filt_cnt_ff;
  logic [15:0] nxt_filt_cnt;
  logic        pin_rst_ff;
  logic        nxt_pin_rst;
  logic        supply_en_ff;
  logic        power_fail;
  logic        low_supply_reset;
  logic        any_src;
  logic [1:0]  rst_sync_ff;
  logic        core_rst_n;

  assign power_fail       = (regulator_pct < crac_pkg::POR_RISE_PCT)
                         || (regulator_pct < crac_pkg::POR_DIST_PCT);
  assign low_supply_reset = supply_en_ff & supply_monitor;
  assign ext_reset_pin_n_out = 1'b0;
  assign ext_reset_pin_n_oe  = low_supply_reset;

  // Pin must stay low a full filter span; short glitches restart the count
  always_comb begin
    nxt_filt_cnt = filt_cnt_ff;
    nxt_pin_rst  = pin_rst_ff;
    if (ext_reset_pin_n_in) begin
      nxt_filt_cnt = 16'h0000;
      nxt_pin_rst  = 1'b0;
    end else if (filt_cnt_ff < 16'(FILTER_CYC - 1)) begin
      nxt_filt_cnt = filt_cnt_ff + 16'h0001;
    end else begin
      nxt_pin_rst = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      filt_cnt_ff <= 16'h0000;
      pin_rst_ff  <= 1'b0;
    end else begin
      filt_cnt_ff <= nxt_filt_cnt;
      pin_rst_ff  <= nxt_pin_rst;
    end
  end

  assign any_src = power_fail | pin_rst_ff | low_supply_reset
                 | watchdog_counter_expired;

  // Assert on the first clock edge that sees any source, release after two clean clock edges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'b00;
    end else if (any_src) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign core_rst_n  = rst_sync_ff[1];
  assign sys_reset_n = core_rst_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0]  stk_lo_ff,  nxt_stk_lo;
  logic [7:0]  stk_hi_ff,  nxt_stk_hi;
  logic [3:0]  amc_ff,     nxt_amc;
  logic [7:0]  stw_ff,     nxt_stw;
  logic [7:0]  movx_hi_ff, nxt_movx_hi;
  logic [7:0]  main_ff,    nxt_main;
  logic [7:0]  aux_ff,     nxt_aux;
  logic [3:0]  wait_ff,    nxt_wait;
  logic        nxt_supply_en;
  logic [7:0]  ptl_ff,     nxt_ptl;
  logic [7:0]  wd_to_ff,   nxt_wd_to;
  logic        wd_en_ff,   nxt_wd_en;
  logic [7:0]  pop_ff,     nxt_pop;
  logic [7:0]  iram [0:255];
  crac_pkg::crac_guard_t guard_ff, nxt_guard;
  logic [1:0]  guard_cnt_ff, nxt_guard_cnt;
  logic [31:0] nxt_prdata;
  logic        nxt_slverr;
  logic        acc_wr;
  logic        acc_setup;
  logic        in_map;
  logic [9:0]  widx;
  logic [7:0]  wbyte;
  logic        hit;
  logic        wide_ff_mode;
  logic [7:0]  push_addr8;
  logic [7:0]  bit_mask;

  assign widx      = paddr[11:2];
  assign in_map    = (widx[9:8] == 2'b00);
  assign acc_wr    = psel & penable & pwrite & in_map;
  assign acc_setup = psel & ~penable;
  assign wbyte     = pwdata[7:0];
  assign pready    = 1'b1;

  assign wide_ff_mode = amc_ff[crac_pkg::AMC_MODE_HI];
  assign push_addr8   = stk_lo_ff + 8'h01;
  assign bit_mask     = 8'(8'h01 << pwdata[10:8]);

  always_comb begin
    nxt_stk_lo    = stk_lo_ff;
    nxt_stk_hi    = stk_hi_ff;
    nxt_amc       = amc_ff;
    nxt_stw       = stw_ff;
    nxt_movx_hi   = movx_hi_ff;
    nxt_main      = main_ff;
    nxt_aux       = aux_ff;
    nxt_wait      = wait_ff;
    nxt_supply_en = supply_en_ff;
    nxt_ptl       = ptl_ff;
    nxt_wd_to     = wd_to_ff;
    nxt_wd_en     = wd_en_ff;
    nxt_pop       = pop_ff;
    nxt_guard     = guard_ff;
    nxt_guard_cnt = guard_cnt_ff;
    nxt_prdata    = 32'h0000_0000;
    nxt_slverr    = 1'b0;
    hit           = 1'b1;
    // Open window closes after a few cycles if unused; an address mode write closes it at once
    if (guard_ff != crac_pkg::CRAC_GUARD_LOCKED) begin
      if (guard_cnt_ff == 2'h0) begin
        nxt_guard = crac_pkg::CRAC_GUARD_LOCKED;
      end else begin
        nxt_guard_cnt = guard_cnt_ff - 2'h1;
      end
    end
    if (stack_push) begin
      nxt_stk_lo = push_addr8;
    end else if (stack_pop) begin
      nxt_pop    = iram[stk_lo_ff];
      nxt_stk_lo = stk_lo_ff - 8'h01;
    end
    if (acc_wr) begin
      unique case (widx[7:0])
        crac_pkg::IDX_STK_LO:    nxt_stk_lo  = wbyte;
        crac_pkg::IDX_STK_HI:    nxt_stk_hi  = wbyte;
        crac_pkg::IDX_ADDR_MODE: begin
          if (guard_ff == crac_pkg::CRAC_GUARD_OPEN) begin
            nxt_amc   = {wbyte[3], 1'b0, wbyte[1:0]};
            nxt_guard = crac_pkg::CRAC_GUARD_LOCKED;
          end
        end
        crac_pkg::IDX_STAT_WORD: nxt_stw     = wbyte;
        crac_pkg::IDX_MOVX_HI:   nxt_movx_hi = wbyte;
        crac_pkg::IDX_MAIN_OP:   nxt_main    = wbyte;
        crac_pkg::IDX_AUX_OP:    nxt_aux     = wbyte;
        crac_pkg::IDX_WAIT:      nxt_wait    = wbyte[3:0];
        crac_pkg::IDX_RST_CTRL:  nxt_supply_en = wbyte[crac_pkg::RC_SUPPLY_EN];
        crac_pkg::IDX_MOVX_ADDR: nxt_ptl     = wbyte;
        crac_pkg::IDX_GUARD: begin
          nxt_guard_cnt = 2'(crac_pkg::GUARD_WIN_CYC);
          if (wbyte == crac_pkg::GUARD_KEY1) begin
            nxt_guard = crac_pkg::CRAC_GUARD_KEY1;
          end else if (wbyte == crac_pkg::GUARD_KEY2
                       && guard_ff == crac_pkg::CRAC_GUARD_KEY1) begin
            nxt_guard = crac_pkg::CRAC_GUARD_OPEN;
          end else begin
            nxt_guard = crac_pkg::CRAC_GUARD_LOCKED;
          end
        end
        crac_pkg::IDX_BITOP: begin
          // Bit write: [11] selects aux, [10:8] bit number, [0] value
          if (pwdata[11]) begin
            nxt_aux  = pwdata[0] ? (aux_ff | bit_mask) : (aux_ff & ~bit_mask);
          end else begin
            nxt_main = pwdata[0] ? (main_ff | bit_mask) : (main_ff & ~bit_mask);
          end
        end
        default: ;
      endcase
    end
    // Decoded at setup so data and error stand in the access phase;
    // a push or pop between setup and access is not seen by that read
    if (acc_setup) begin
      unique case (widx[7:0])
        crac_pkg::IDX_STK_LO:    nxt_prdata[7:0] = stk_lo_ff;
        crac_pkg::IDX_STK_HI:    nxt_prdata[7:0] = stk_hi_ff;
        crac_pkg::IDX_ADDR_MODE: nxt_prdata[7:0] = {4'h0, amc_ff[3], wide_ff_mode,
                                                    amc_ff[1:0]};
        crac_pkg::IDX_STAT_WORD: nxt_prdata[7:0] = stw_ff;
        crac_pkg::IDX_MOVX_HI:   nxt_prdata[7:0] = movx_hi_ff;
        crac_pkg::IDX_MAIN_OP:   nxt_prdata[7:0] = main_ff;
        crac_pkg::IDX_AUX_OP:    nxt_prdata[7:0] = aux_ff;
        crac_pkg::IDX_WAIT:      nxt_prdata[7:0] = {4'h0, wait_ff};
        crac_pkg::IDX_RST_CTRL:  nxt_prdata[7:0] = {7'h00, supply_en_ff};
        crac_pkg::IDX_MOVX_ADDR: nxt_prdata[7:0] = ptl_ff;
        crac_pkg::IDX_GUARD:     nxt_prdata[7:0] = 8'h00;
        crac_pkg::IDX_BITOP:     nxt_prdata[7:0] = 8'h00;
        crac_pkg::IDX_CORE_STAT: nxt_prdata[7:0] = {6'h00, supply_monitor, power_fail};
        default:                 hit = 1'b0;
      endcase
      nxt_slverr = ~hit | ~in_map;
      if (pwrite || !in_map) begin
        nxt_prdata = 32'h0000_0000;
      end
    end
  end

  // Core registers take defaults on the combined reset
  always_ff @(posedge clk_sys or negedge core_rst_n) begin
    if (!core_rst_n) begin
      stk_lo_ff    <= crac_pkg::RST_BYTE;
      stk_hi_ff    <= crac_pkg::RST_BYTE;
      amc_ff       <= 4'h0;
      stw_ff       <= crac_pkg::RST_BYTE;
      movx_hi_ff   <= crac_pkg::RST_BYTE;
      main_ff      <= crac_pkg::RST_BYTE;
      aux_ff       <= crac_pkg::RST_BYTE;
      wait_ff      <= crac_pkg::RST_WAIT;
      supply_en_ff <= 1'b0;
      ptl_ff       <= crac_pkg::RST_BYTE;
      wd_to_ff     <= crac_pkg::WDOG_MAX;
      wd_en_ff     <= 1'b1;
      pop_ff       <= crac_pkg::RST_BYTE;
      guard_ff     <= crac_pkg::CRAC_GUARD_LOCKED;
      guard_cnt_ff <= 2'h0;
      prdata       <= 32'h0000_0000;
      pslverr      <= 1'b0;
    end else begin
      stk_lo_ff    <= nxt_stk_lo;
      stk_hi_ff    <= nxt_stk_hi;
      amc_ff       <= nxt_amc;
      stw_ff       <= nxt_stw;
      movx_hi_ff   <= nxt_movx_hi;
      main_ff      <= nxt_main;
      aux_ff       <= nxt_aux;
      wait_ff      <= nxt_wait;
      supply_en_ff <= nxt_supply_en;
      ptl_ff       <= nxt_ptl;
      wd_to_ff     <= nxt_wd_to;
      wd_en_ff     <= nxt_wd_en;
      pop_ff       <= nxt_pop;
      guard_ff     <= nxt_guard;
      guard_cnt_ff <= nxt_guard_cnt;
      prdata       <= nxt_prdata;
      pslverr      <= nxt_slverr;
    end
  end

  // Stack memory carries no reset; contents are undefined after power-up
  always_ff @(posedge clk_sys) begin
    if (stack_push && !wide_ff_mode) begin
      iram[push_addr8] <= stack_push_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Derived outputs

  assign wide_mode    = wide_ff_mode;
  assign compact_mode = (amc_ff[1:0] == 2'b00);
  assign stack_addr   = wide_ff_mode ? {stk_hi_ff, stk_lo_ff}
                                     : {8'h00, stk_lo_ff};
  assign stack_pop_data = pop_ff;
  assign movx_addr    = {(amc_ff[crac_pkg::AMC_PAGE_SRC] ? movx_hi_ff
                                                        : ptl_ff), movx_ri_low};
  assign port_two_latch        = ptl_ff;
  assign fetch_wait_cycles_m1  = wait_ff;
  assign boot_pc               = crac_pkg::BOOT_VECTOR;
  assign internal_osc_sel      = 1'b1;
  assign internal_osc_en       = ~(stop_mode | sleep_mode);
  assign watchdog_counter_en      = wd_en_ff;
  assign watchdog_counter_timeout = wd_to_ff;

endmodule

// *** hdl/crac_pkg.sv ***
// Package with register map, field layout, reset values and timing constants
package crac_pkg;

  // Register indices; the byte address on the bus is index * 4
  localparam logic [7:0] IDX_STK_LO    = 8'h81;
  localparam logic [7:0] IDX_WAIT      = 8'h92;
  localparam logic [7:0] IDX_STK_HI    = 8'h9B;
  localparam logic [7:0] IDX_ADDR_MODE = 8'h9D;
  localparam logic [7:0] IDX_STAT_WORD = 8'hD0;
  localparam logic [7:0] IDX_MOVX_HI   = 8'hDA;
  localparam logic [7:0] IDX_MAIN_OP   = 8'hE0;
  localparam logic [7:0] IDX_AUX_OP    = 8'hF0;
  localparam logic [7:0] IDX_GUARD     = 8'hC7;
  localparam logic [7:0] IDX_RST_CTRL  = 8'hC8;
  localparam logic [7:0] IDX_BITOP     = 8'hC9;
  localparam logic [7:0] IDX_CORE_STAT = 8'hCA;
  localparam logic [7:0] IDX_MOVX_ADDR = 8'hCB;

  // Reset values
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [3:0]  RST_WAIT     = 4'h7;
  localparam logic [19:0] BOOT_VECTOR  = 20'h0F000;
  localparam logic [7:0]  WDOG_MAX     = 8'hFF;

  // Address mode control fields
  localparam int AMC_PAGE_SRC = 3;
  localparam int AMC_EXT_STK  = 2;
  localparam int AMC_MODE_HI  = 1;

  // Reset control fields
  localparam int RC_SUPPLY_EN = 0;

  // Timed-access unlock keys and window
  localparam logic [7:0] GUARD_KEY1 = 8'hAA;
  localparam logic [7:0] GUARD_KEY2 = 8'h55;
  localparam int         GUARD_WIN_CYC = 3;

  // Supply thresholds in percent of target
  localparam logic [6:0] POR_RISE_PCT = 7'h5A;
  localparam logic [6:0] POR_DIST_PCT = 7'h46;

  // Pin filter timing
  localparam int CLK_MHZ        = 25;
  localparam int PIN_FILTER_US  = 5;
  localparam int PIN_FILTER_CYC = PIN_FILTER_US * CLK_MHZ;
  localparam int PIN_HOLD_US    = 50;

  typedef enum logic [1:0] {
    CRAC_GUARD_LOCKED,
    CRAC_GUARD_KEY1,
    CRAC_GUARD_OPEN
  } crac_guard_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } crac_apb_req_t;

endpackage

// *** verification/crac_core_monitor.sv ***
// Concurrent checks on the core reset and register block ports
`timescale 1ns/100ps
module crac_mon (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [6:0]  regulator_pct,
  input wire logic        supply_monitor,
  input wire logic        ext_reset_pin_n_out,
  input wire logic        ext_reset_pin_n_oe,
  input wire logic        watchdog_counter_expired,
  input wire logic        stop_mode,
  input wire logic        sleep_mode,
  input wire logic [7:0]  movx_ri_low,
  input wire logic [15:0] movx_addr,
  input wire logic        sys_reset_n,
  input wire logic        internal_osc_en,
  input wire logic        internal_osc_sel,
  input wire logic        watchdog_counter_en,
  input wire logic [7:0]  watchdog_counter_timeout,
  input wire logic [19:0] boot_pc,
  input wire logic        wide_mode,
  input wire logic        compact_mode,
  input wire logic [3:0]  fetch_wait_cycles_m1
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////////
  osc_gate_a: assert property (internal_osc_en == !(stop_mode || sleep_mode))
    else $error("oscillator enable wrong");
  boot_state_a: assert property ($rose(sys_reset_n) |->
    internal_osc_sel && boot_pc == 20'h0F000)
    else $error("boot state wrong");
  wdog_dflt_a: assert property (!sys_reset_n [*2] |->
    watchdog_counter_en && watchdog_counter_timeout == 8'hFF)
    else $error("watchdog not at maximum in reset");
  reg_dflt_a: assert property ($rose(sys_reset_n) |->
    fetch_wait_cycles_m1 == 4'h7 && compact_mode)
    else $error("defaults wrong at release");
  pin_drive_a: assert property (ext_reset_pin_n_oe |->
    supply_monitor && !ext_reset_pin_n_out)
    else $error("pin driven without low supply");
  por_src_a: assert property (regulator_pct < 7'h5A |-> ##[0:2] !sys_reset_n)
    else $error("power fail gave no reset");
  wdog_src_a: assert property (watchdog_counter_expired |-> ##[0:2] !sys_reset_n)
    else $error("watchdog gave no reset");
  lsr_src_a: assert property (ext_reset_pin_n_oe |-> ##[0:2] !sys_reset_n)
    else $error("low supply gave no reset");
  hold_rst_a: assert property (!sys_reset_n && regulator_pct < 7'h5A |=> !sys_reset_n)
    else $error("reset released with source active");
  movx_low_a: assert property (movx_addr[7:0] == movx_ri_low)
    else $error("movx low byte wrong");
  mode_excl_a: assert property (wide_mode |-> !compact_mode)
    else $error("both modes at once");
  cover property (ext_reset_pin_n_oe);
  cover property (wide_mode);
  cover property ($fell(sys_reset_n));
endmodule
//////////////////////////////////////////////////////////////////////////////
bind crac_core crac_mon u_mon (
  .clk_sys(clk_sys), .reset_n(reset_n), .regulator_pct(regulator_pct),
  .supply_monitor(supply_monitor), .ext_reset_pin_n_out(ext_reset_pin_n_out),
  .ext_reset_pin_n_oe(ext_reset_pin_n_oe), .watchdog_counter_expired(watchdog_counter_expired),
  .stop_mode(stop_mode), .sleep_mode(sleep_mode), .movx_ri_low(movx_ri_low),
  .movx_addr(movx_addr), .sys_reset_n(sys_reset_n), .internal_osc_en(internal_osc_en),
  .internal_osc_sel(internal_osc_sel), .watchdog_counter_en(watchdog_counter_en),
  .watchdog_counter_timeout(watchdog_counter_timeout), .boot_pc(boot_pc),
  .wide_mode(wide_mode), .compact_mode(compact_mode),
  .fetch_wait_cycles_m1(fetch_wait_cycles_m1)
);

// *** verification/tb.sv ***
// Self-checking bench for the core reset and register block
`timescale 1ns/100ps
module tb;
  logic                    clk_sys = 1'b0;
  logic                    reset_n = 1'b0;
  crac_pkg::crac_apb_req_t req     = '0;
  logic [6:0]              reg_pct = 7'h5A;
  logic                    sup_mon = 0, pin_drv = 1, wd_exp = 0, stop_m = 0, sleep_m = 0;
  logic                    push = 0, pop = 0, pready, pslverr, pin_out, pin_oe, srst_n;
  logic                    osc_en, osc_sel, wd_en, wide, compact, e, low;
  logic [7:0]              push_d = 0, ri_low = 0, pop_d, wd_to, ptl;
  logic [2:0]              bn;
  logic [31:0]             prdata, r;
  logic [15:0]             stk_a, movx_a;
  logic [19:0]             boot_pc;
  logic [3:0]              wait_m1;
  int                      n_mismatch = 0, checks = 0, seed = 24, cyc = 0, mdl [int];
  wire                     pin_in = pin_oe ? pin_out : pin_drv;
  localparam logic [7:0]   RIDX [8] = '{8'h81, 8'h92, 8'h9B, 8'hD0, 8'hDA, 8'hE0, 8'hF0, 8'hCB};
  // Small filter count keeps the pin tests short
  crac_core #(.FILTER_CYC(4)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(req.psel), .penable(req.penable),
    .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .regulator_pct(reg_pct), .supply_monitor(sup_mon),
    .ext_reset_pin_n_in(pin_in), .ext_reset_pin_n_out(pin_out), .ext_reset_pin_n_oe(pin_oe),
    .watchdog_counter_expired(wd_exp), .stop_mode(stop_m), .sleep_mode(sleep_m),
    .stack_push(push), .stack_pop(pop), .stack_push_data(push_d), .movx_ri_low(ri_low),
    .sys_reset_n(srst_n), .internal_osc_en(osc_en), .internal_osc_sel(osc_sel),
    .watchdog_counter_en(wd_en), .watchdog_counter_timeout(wd_to), .boot_pc(boot_pc),
    .stack_addr(stk_a), .stack_pop_data(pop_d), .movx_addr(movx_a), .wide_mode(wide),
    .compact_mode(compact), .fetch_wait_cycles_m1(wait_m1), .port_two_latch(ptl)
  );
  always #20 clk_sys = ~clk_sys;
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("unexpected at %0t: run hung", $time);
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Read data and error stand in the access phase and are taken at its edge
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, w, {2'b00, i, 2'b00}, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      r = prdata;
      e = pslverr;
    end while (pready !== 1'b1);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
    chk(e, 1'b0, "write error");
    mdl[i] = (i == 8'h92) ? d & 32'hF : d & 32'hFF;
  endtask
  task automatic rdc(input logic [7:0] i);
    apb(1'b0, i, 32'h0);
    chk(r, mdl[i], "read data");
    chk(e, 1'b0, "read error");
  endtask
  task automatic rdall();
    foreach (RIDX[i]) rdc(RIDX[i]);
    rdc(8'h9D);
    rdc(8'hCA);
    chk({ptl, wait_m1}, {8'(mdl[8'hCB]), 4'(mdl[8'h92])}, "latch outputs");
  endtask
  task automatic mreset();
    foreach (RIDX[i]) mdl[RIDX[i]] = 0;
    mdl[8'h92] = 7;
    mdl[8'h9D] = 0;
    mdl[8'hC8] = 0;
    mdl[8'hCA] = 0;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1 chk(srst_n, 1'b1, "reset release");
  endtask
  // Mode bits only land when the unlock pair precedes them within the window
  task automatic amc(input logic [7:0] v, input bit unlock);
    int old;
    old = mdl[8'h9D];
    if (unlock) begin
      wr(8'hC7, {24'h0, crac_pkg::GUARD_KEY1});
      wr(8'hC7, {24'h0, crac_pkg::GUARD_KEY2});
    end
    wr(8'h9D, {24'h0, v});
    mdl[8'h9D] = unlock ? {28'h0, v[3], v[1], v[1:0]} : old;
    rdc(8'h9D);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    mreset();
    settle();
    rdall();
    chk({osc_sel, wd_en, wd_to, boot_pc}, {2'b11, 8'hFF, 20'h0F000}, "boot");
    for (int n = 0; n < 3; n++) begin
      @(posedge clk_sys);
      {stop_m, sleep_m, ri_low} <= 10'($random(seed));
      foreach (RIDX[i]) wr(RIDX[i], $random(seed));
      rdall();
    end
    apb(1'b0, 8'h00, 32'h0);
    chk(e, 1'b1, "unmapped");
    push_d <= 8'($random(seed));
    wr(8'h81, 32'h40);
    @(posedge clk_sys);
    push <= 1'b1;
    @(posedge clk_sys);
    push <= 1'b0;
    wr(8'h81, 32'h41);
    @(posedge clk_sys);
    pop <= 1'b1;
    @(posedge clk_sys);
    pop <= 1'b0;
    #1 chk(pop_d, push_d, "pop data");
    amc(8'h0A, 1'b1);
    wr(8'h9B, 32'h12);
    wr(8'h81, 32'h34);
    chk(stk_a, 16'h1234, "wide stack");
    chk({wide, compact, movx_a[15:8]}, {2'b10, 8'(mdl[8'hDA])}, "wide");
    amc(8'h03, 1'b0);
    amc(8'h04, 1'b1);
    chk({wide, compact, movx_a[15:8]}, {2'b01, 8'(mdl[8'hCB])}, "compact");
    for (int n = 0; n < 4; n++) begin
      low = 1'($random(seed));
      bn = 3'($random(seed));
      wr(8'hC9, {20'h0, n[0], bn, 7'h0, low});
      mdl[n[0] ? 8'hF0 : 8'hE0][bn] = low;
      rdc(8'hE0);
      rdc(8'hF0);
    end
    // Short pin low, monitor unarmed and level at threshold: none may reset
    @(posedge clk_sys);
    pin_drv <= 1'b0;
    sup_mon <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pin_drv <= 1'b1;
    sup_mon <= 1'b0;
    rdall();
    for (int k = 0; k < 6; k++) begin
      wr(8'hE0, 32'($random(seed) | 1));
      if (k == 5) wr(8'hC8, 32'h1);
      @(posedge clk_sys);
      case (k)
        0: reg_pct <= 7'h59;
        1: reg_pct <= 7'h45;
        2: wd_exp <= 1'b1;
        3: pin_drv <= 1'b0;
        4: reset_n <= 1'b0;
        default: sup_mon <= 1'b1;
      endcase
      #1;
      if (k == 5) chk({pin_oe, pin_out}, 2'b10, "pin drive");
      low = 1'b0;
      repeat (8) begin
        @(posedge clk_sys);
        if (srst_n === 1'b0) low = 1'b1;
      end
      reg_pct <= 7'h5A;
      wd_exp <= 1'b0;
      pin_drv <= 1'b1;
      reset_n <= 1'b1;
      sup_mon <= 1'b0;
      chk(low, 1'b1, "reset source");
      mreset();
      settle();
      rdc(8'hE0);
      rdc(8'hC8);
    end
    test_done();
  end
endmodule
